//--- dv/aowf_checker.sv
// Port assertions for the axis word formatter
`timescale 1ns/1ps
module aowf_checker (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire sample_valid_i,
  input wire self_test_o,
  input wire [3:0] rate_o,
  input wire sample_ready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i & stb_i & ~ack_o & ce_i;
  wire wr = req & we_i & sel_i[0];
  property p_ack; req |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack1; ack_o && ce_i |=> !ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack too long");
  property p_rdy; sample_valid_i && ce_i |=> sample_ready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_rdyc; sample_ready_o && $past(ce_i) |-> $past(sample_valid_i);
  endproperty
  a_rdyc: assert property (p_rdyc) else $error("ready stray");
  property p_st; wr && adr_i == 8'h00 |=> self_test_o == $past(dat_i[7]);
  endproperty
  a_st: assert property (p_st) else $error("self test bit");
  property p_sth; !(wr && adr_i == 8'h00) |=> $stable(self_test_o);
  endproperty
  a_sth: assert property (p_sth) else $error("self test moved");
  property p_rate; wr && adr_i == 8'h04 |=> rate_o == $past(dat_i[3:0]);
  endproperty
  a_rate: assert property (p_rate) else $error("rate code");
  property p_scale; req && !we_i && adr_i == 8'h0C |=>
    dat_o == 32'h0000_0B54; endproperty
  a_scale: assert property (p_scale) else $error("scale");
  property p_hi; ack_o && !we_i && adr_i >= 8'h10 |->
    dat_o[31:8] == 24'h00_0000; endproperty
  a_hi: assert property (p_hi) else $error("upper bits");
endmodule
bind aowf_top aowf_checker aowf_checker_inst (.clk_i, .rst_i, .ce_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sample_valid_i,
  .self_test_o, .rate_o, .sample_ready_o);

//--- dv/aowf_src.sv
// Converter stand-in: one raw sample per request
`timescale 1ns/1ps
module aowf_src (
  input wire clk_i,
  input wire fire_i,
  input wire [12:0] val_i,
  output reg valid_o,
  output reg [12:0] x_o,
  output reg [12:0] y_o,
  output reg [12:0] z_o
);
  // Stale data is inverted so a late capture cannot pass
  always @(posedge clk_i) begin
    valid_o <= fire_i;
    x_o <= fire_i ? val_i : ~val_i;
    y_o <= fire_i ? ~val_i : val_i;
    z_o <= fire_i ? val_i + 13'h0001 : ~(val_i + 13'h0001);
  end
endmodule

//--- dv/tb.sv
// Self-checking bench for the axis word formatter
`timescale 1ns/1ps
module tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0, stb = 0, we = 0, fire = 0, sv, ack, st, rdy;
  logic ce = 1;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, rd, dq;
  logic [12:0] val = 0, sx, sy, sz;
  logic [3:0] rt;
  int mismatches = 0, samples_checked = 0;
  aowf_src aowf_src_inst (.clk_i, .fire_i(fire), .val_i(val), .valid_o(sv),
    .x_o(sx), .y_o(sy), .z_o(sz));
  aowf_top aowf_top_inst (.clk_i, .rst_i, .ce_i(ce), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat),
    .dat_o(dq), .ack_o(ack), .sample_valid_i(sv), .sample_x_i(sx),
    .sample_y_i(sy), .sample_z_i(sz), .self_test_o(st), .rate_o(rt),
    .sample_ready_o(rdy));
  initial forever #4 clk_i = ~clk_i;
  task report_and_stop;
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task tmo(input logic ok);
    if (ok !== 1'b1) begin
      mismatches++;
      report_and_stop;
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    tmo(ack);
    rd = dq;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask
  task samp(input logic [12:0] v);
    int n;
    val <= v;
    fire <= 1;
    @(posedge clk_i);
    fire <= 0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rdy !== 1'b1 && n < 8);
    tmo(rdy);
  endtask
  task sc_reset;
    rdc("fmt", 8'h00, 32'h0000_0000);
    rdc("rate", 8'h04, 32'h0000_000A);
    rdc("scale", 8'h0C, 32'h0000_0B54);
    rdc("hole", 8'h3C, 32'h0000_0000);
  endtask
  task sc_high;
    wb(1, 8'h04, 32'h0000_000F);
    for (int r = 0; r < 4; r++) begin
      wb(1, 8'h00, 32'h0000_000C | r);
      samp(13'h0003);
      rdc("left", 8'h10, (32'h0000_0002 << (6 - r)) & 32'h0000_00FF);
    end
    wb(1, 8'h00, 32'h0000_0004);
    samp(13'h0003);
    rdc("left10", 8'h10, 32'h0000_0080);
    wb(1, 8'h00, 32'h0000_0008);
    samp(13'h1FFB);
    rdc("rlo", 8'h10, 32'h0000_00FA);
    rdc("rhi", 8'h14, 32'h0000_00FF);
    rdc("ylo", 8'h18, 32'h0000_0004);
    rdc("yhi", 8'h1C, 32'h0000_0000);
    rdc("zlo", 8'h20, 32'h0000_00FC);
    rdc("zhi", 8'h24, 32'h0000_00FF);
    wb(1, 8'h00, 32'h0000_0009);
    samp(13'h01FF);
    rdc("r3g", 8'h14, 32'h0000_0001);
  endtask
  task sc_live;
    wb(1, 8'h00, 32'h0000_0003);
    samp(13'h0018);
    rdc("live", 8'h10, 32'h0000_0003);
    wb(1, 8'h04, 32'h0000_000D);
    wb(1, 8'h00, 32'h0000_000C);
    samp(13'h0003);
    rdc("slow", 8'h10, 32'h0000_00C0);
  endtask
  task sc_freeze;
    ce <= 0;
    val <= 13'h0001;
    fire <= 1;
    @(posedge clk_i);
    fire <= 0;
    repeat (2) @(posedge clk_i);
    chk("frozen ready", 32'h0000_0000, {31'h0000_0000, rdy});
    @(posedge clk_i);
    ce <= 1;
    @(posedge clk_i);
    rdc("frozen word", 8'h10, 32'h0000_00C0);
  endtask
  task sc_rerst;
    wb(1, 8'h04, 32'h0000_000F);
    wb(1, 8'h00, 32'h0000_008B);
    samp(13'h0005);
    rdc("busy status", 8'h08, 32'h0000_0016);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rdc("rst fmt", 8'h00, 32'h0000_0000);
    rdc("rst rate", 8'h04, 32'h0000_000A);
    rdc("rst word", 8'h10, 32'h0000_0000);
    rdc("rst status", 8'h08, 32'h0000_0000);
  endtask
  task sc_selftest;
    wb(1, 8'h00, 32'h0000_0080);
    repeat (3) samp(13'h0000);
    wb(0, 8'h08, 32'h0000_0000);
    chk("early", 32'h0000_0000, rd & 32'h0000_0001);
    samp(13'h0000);
    wb(0, 8'h08, 32'h0000_0000);
    chk("settle", 32'h0000_0001, rd & 32'h0000_0001);
    wb(1, 8'h00, 32'h0000_0000);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    sc_reset;
    sc_high;
    sc_live;
    sc_freeze;
    sc_selftest;
    sc_rerst;
    report_and_stop;
  end
endmodule

//--- inc/aowf_consts.vh
// Register map, field positions, reset values and timing counts
`ifndef AOWF_CONSTS_VH
`define AOWF_CONSTS_VH

// Byte offsets on the register bus
`define AOWF_ADR_FORMAT 8'h00
`define AOWF_ADR_RATE 8'h04
`define AOWF_ADR_STATUS 8'h08
`define AOWF_ADR_SCALE 8'h0C
`define AOWF_ADR_X_LO 8'h10
`define AOWF_ADR_X_HI 8'h14
`define AOWF_ADR_Y_LO 8'h18
`define AOWF_ADR_Y_HI 8'h1C
`define AOWF_ADR_Z_LO 8'h20
`define AOWF_ADR_Z_HI 8'h24

// Output format register fields
`define AOWF_FMT_RANGE_LO 0
`define AOWF_FMT_RANGE_HI 1
`define AOWF_FMT_LEFT_JUST 2
`define AOWF_FMT_FULL_RES 3
`define AOWF_FMT_SELF_TEST 7
`define AOWF_FMT_WR_MASK 8'h8F
`define AOWF_FMT_RESET 8'h00

// Range field codes
`define AOWF_RANGE_1G5 2'h0
`define AOWF_RANGE_3G 2'h1
`define AOWF_RANGE_6G 2'h2
`define AOWF_RANGE_12G 2'h3

// Output data rate field, low four bits of the rate register
`define AOWF_RATE_RESET 4'hA
`define AOWF_RATE_1600HZ 4'hE
`define AOWF_RATE_3200HZ 4'hF

// Status register fields
`define AOWF_ST_SETTLED 0
`define AOWF_ST_HIGH_RATE 1
`define AOWF_ST_LSB_FORCED 2
`define AOWF_ST_CNT_LO 4
`define AOWF_ST_CNT_HI 6

// Samples to wait after self-test is switched on
`define AOWF_SETTLE_SAMPLES 3'h4

// Full-resolution weight of one LSB, micro-g
`define AOWF_SCALE_UG_PER_LSB 16'h0B54

// Widths and justification geometry
`define AOWF_RAW_W 13
`define AOWF_WORD_W 16
`define AOWF_FIXED_W 4'hA
`define AOWF_LEFT_SHIFT_BASE 4'h6

`endif

//--- rtl/aowf_axis_fmt.v
// One axis: raw sample to 16-bit justified output word
`timescale 1ns/1ps
`include "aowf_consts.vh"

module aowf_axis_fmt (
  input wire [12:0] raw_i,
  input wire [1:0] range_i,
  input wire full_res_i,
  input wire left_just_i,
  input wire force_lsb0_i,
  output wire [15:0] word_o
);

  wire signed [12:0] raw_s;
  wire signed [12:0] fixed_s;
  wire [12:0] value;
  wire [15:0] right_word;
  wire [3:0] left_shift;

  assign raw_s = raw_i;
  // Fixed mode keeps 10 bits, so its LSB weight grows with range
  assign fixed_s = raw_s >>> range_i;
  // Full resolution keeps one weight in every range
  assign value = full_res_i ? raw_i : fixed_s; // RULE8

  // Sign extension above the MSB when right justified
  assign right_word = {{3{value[12]}}, value[12:1],
                       value[0] & ~force_lsb0_i}; // RULE2 RULE11 RULE7

  // Left justified: MSB at bit 15, LSB at 6, 5, 4 or 3 of the low byte
  assign left_shift = full_res_i ?
    (`AOWF_LEFT_SHIFT_BASE - {2'b00, range_i}) :
    `AOWF_LEFT_SHIFT_BASE; // RULE3 RULE4

  assign word_o = left_just_i ? (right_word << left_shift) : right_word;

endmodule

//--- rtl/aowf_top.v
// Axis output word formatter with classic Wishbone register slave
//
// Contract
// RULE1 - Top two rates, full-res or 1.5g: LSB zero
// RULE2 - Right justified: LSB at low byte bit 0
// RULE3 - Left justified 10-bit 1.5g: LSB bit 6
// RULE4 - Left full-res LSB: bits 6,5,4,3 by range
// RULE5 - Fixed 10-bit higher ranges keep a live LSB
// RULE6 - At 800 Hz or below LSB always live
// RULE7 - Right full-res: MSB moves, LSB stays put
// RULE8 - Full-res LSB has one fixed g weight
// RULE9 - Format bit 3 full-res, range code 3 12g
// RULE10 - Format bit 7 self-test, four samples settle
// RULE11 - 16-bit two's complement, low/high byte pair
`timescale 1ns/1ps
`include "aowf_consts.vh"

module aowf_top (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Classic Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Raw samples from the converter, same clock
  input wire sample_valid_i,
  input wire [12:0] sample_x_i,
  input wire [12:0] sample_y_i,
  input wire [12:0] sample_z_i,
  // Control to the sensing element, and sample_ready_o flagging a newly latched sample
  output wire self_test_o,
  output wire [3:0] rate_o,
  output reg sample_ready_o
);

  reg [7:0] format_reg;
  reg [3:0] rate_reg;
  reg [2:0] settle_cnt;
  reg [15:0] word_x;
  reg [15:0] word_y;
  reg [15:0] word_z;
  reg [31:0] next_dat;

  wire bus_req;
  wire wr_lane0;
  wire [1:0] range_sel;
  wire full_res;
  wire left_just;
  wire self_test;
  wire high_rate;
  wire force_lsb0;
  wire settled;
  wire [38:0] raw_bus;
  wire [47:0] word_bus;
  wire [7:0] status_val;
  wire hit_format;
  wire hit_rate;
  wire hit_status;
  wire hit_scale;
  wire hit_x_lo;
  wire hit_x_hi;
  wire hit_y_lo;
  wire hit_y_hi;
  wire hit_z_lo;
  wire hit_z_hi;

  // A new request only when no answer is outstanding
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr_lane0 = bus_req & we_i & sel_i[0];

  // Decoded once, so the write and read paths share one map
  assign hit_format = (adr_i == `AOWF_ADR_FORMAT);
  assign hit_rate = (adr_i == `AOWF_ADR_RATE);
  assign hit_status = (adr_i == `AOWF_ADR_STATUS);
  assign hit_scale = (adr_i == `AOWF_ADR_SCALE);
  assign hit_x_lo = (adr_i == `AOWF_ADR_X_LO);
  assign hit_x_hi = (adr_i == `AOWF_ADR_X_HI);
  assign hit_y_lo = (adr_i == `AOWF_ADR_Y_LO);
  assign hit_y_hi = (adr_i == `AOWF_ADR_Y_HI);
  assign hit_z_lo = (adr_i == `AOWF_ADR_Z_LO);
  assign hit_z_hi = (adr_i == `AOWF_ADR_Z_HI);

  assign range_sel = format_reg[`AOWF_FMT_RANGE_HI:`AOWF_FMT_RANGE_LO]; // RULE9
  assign full_res = format_reg[`AOWF_FMT_FULL_RES]; // RULE9
  assign left_just = format_reg[`AOWF_FMT_LEFT_JUST];
  assign self_test = format_reg[`AOWF_FMT_SELF_TEST]; // RULE10

  assign high_rate = (rate_reg == `AOWF_RATE_3200HZ) |
                     (rate_reg == `AOWF_RATE_1600HZ); // RULE6
  // Fixed mode above 1.5g drops bits by shifting, so its LSB stays live
  assign force_lsb0 = high_rate &
    (full_res | (range_sel == `AOWF_RANGE_1G5)); // RULE1 RULE5

  assign settled = self_test & (settle_cnt == `AOWF_SETTLE_SAMPLES); // RULE10

  assign self_test_o = self_test;
  assign rate_o = rate_reg;

  assign raw_bus = {sample_z_i, sample_y_i, sample_x_i};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_axis
      aowf_axis_fmt u_fmt (
        .raw_i(raw_bus[g*13 +: 13]),
        .range_i(range_sel),
        .full_res_i(full_res),
        .left_just_i(left_just),
        .force_lsb0_i(force_lsb0),
        .word_o(word_bus[g*16 +: 16])
      );
    end
  endgenerate

  // Reserved status bits read zero
  assign status_val[7] = 1'b0;
  assign status_val[`AOWF_ST_CNT_HI:`AOWF_ST_CNT_LO] = settle_cnt;
  assign status_val[3] = 1'b0;
  assign status_val[`AOWF_ST_LSB_FORCED] = force_lsb0; // RULE1
  assign status_val[`AOWF_ST_HIGH_RATE] = high_rate;
  assign status_val[`AOWF_ST_SETTLED] = settled; // RULE10

  // Configuration registers, byte lane 0 only
  always @(posedge clk_i) begin
    if (rst_i) begin
      format_reg <= `AOWF_FMT_RESET;
      rate_reg <= `AOWF_RATE_RESET;
    end else if (ce_i) begin
      if (wr_lane0 && hit_format) begin
        format_reg <= dat_i[7:0] & `AOWF_FMT_WR_MASK; // RULE9 RULE10
      end
      if (wr_lane0 && hit_rate) begin
        rate_reg <= dat_i[3:0];
      end
    end
  end

  // Samples taken since self-test was switched on, held at the limit
  always @(posedge clk_i) begin
    if (rst_i) begin
      settle_cnt <= 3'h0;
    end else if (ce_i) begin
      if (!self_test) begin
        settle_cnt <= 3'h0;
      end else if (sample_valid_i && settle_cnt != `AOWF_SETTLE_SAMPLES) begin
        settle_cnt <= settle_cnt + 3'h1; // RULE10
      end
    end
  end

  // Output words latch on each sample; a format change shows on the next
  always @(posedge clk_i) begin
    if (rst_i) begin
      word_x <= 16'h0000;
      word_y <= 16'h0000;
      word_z <= 16'h0000;
      sample_ready_o <= 1'b0;
    end else if (ce_i) begin
      sample_ready_o <= sample_valid_i;
      if (sample_valid_i) begin
        word_x <= word_bus[15:0]; // RULE11
        word_y <= word_bus[31:16]; // RULE11
        word_z <= word_bus[47:32]; // RULE11
      end
    end
  end

  // Read multiplexer; unmapped offsets read zero and still answer
  always @* begin
    next_dat = 32'h0000_0000;
    if (hit_format) begin
      next_dat = {24'h00_0000, format_reg};
    end
    if (hit_rate) begin
      next_dat = {28'h000_0000, rate_reg};
    end
    if (hit_status) begin
      next_dat = {24'h00_0000, status_val};
    end
    if (hit_scale) begin
      next_dat = {16'h0000, `AOWF_SCALE_UG_PER_LSB}; // RULE8
    end
    if (hit_x_lo) begin
      next_dat = {24'h00_0000, word_x[7:0]}; // RULE11
    end
    if (hit_x_hi) begin
      next_dat = {24'h00_0000, word_x[15:8]}; // RULE11
    end
    if (hit_y_lo) begin
      next_dat = {24'h00_0000, word_y[7:0]};
    end
    if (hit_y_hi) begin
      next_dat = {24'h00_0000, word_y[15:8]};
    end
    if (hit_z_lo) begin
      next_dat = {24'h00_0000, word_z[7:0]};
    end
    if (hit_z_hi) begin
      next_dat = {24'h00_0000, word_z[15:8]};
    end
  end

  // One wait state: ack one edge after the request, dropped the next
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        dat_o <= next_dat;
      end
    end
  end

endmodule
